// ==== acem_pkg.sv ====
package acem_pkg;
  // ***************************************************************
  // register map (word addresses on the plain register port)
  // ***************************************************************
  localparam logic [3:0] ACEM_ADDR_CTRL = 4'h0; // criterion selections
  localparam logic [3:0] ACEM_ADDR_NXT_VAL = 4'h1; // next-header value
  localparam logic [3:0] ACEM_ADDR_SRC_VAL = 4'h2; // source address value
  localparam logic [3:0] ACEM_ADDR_SRC_MASK = 4'h3; // source address mask
  localparam logic [3:0] ACEM_ADDR_MSG_VAL = 4'h4; // type [7:0], code [15:8]
  localparam logic [3:0] ACEM_ADDR_STATUS = 4'h5; // hit [1], result strobe [0]
  localparam logic [3:0] ACEM_ADDR_HITCNT = 4'h6; // hit counter
  // ***************************************************************
  // control register field positions
  // ***************************************************************
  localparam int ACEM_CTRL_NXT_LSB = 0; // 3-bit next-header criterion
  localparam int ACEM_CTRL_SRC_BIT = 4; // source address criterion
  localparam int ACEM_CTRL_HOP_LSB = 8; // 2-bit hop-limit criterion
  localparam int ACEM_CTRL_TYPE_BIT = 12; // message type criterion
  localparam int ACEM_CTRL_CODE_BIT = 13; // message code criterion
  localparam int ACEM_CTRL_EN_BIT = 31; // entry enable
  localparam int ACEM_MSG_CODE_LSB = 8; // code field in value register
  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [31:0] ACEM_CTRL_RST = 32'h0000_0000;
  localparam logic [7:0] ACEM_BYTE_RST = 8'h00;
  localparam logic [31:0] ACEM_WORD_RST = 32'h0000_0000;
  // ***************************************************************
  // protocol numbers for next-header selections
  // ***************************************************************
  localparam logic [7:0] ACEM_PROTO_ICMP6 = 8'h3a;
  localparam logic [7:0] ACEM_PROTO_UDP = 8'h11;
  localparam logic [7:0] ACEM_PROTO_TCP = 8'h06;
  // ***************************************************************
  // criterion encodings
  // ***************************************************************
  typedef enum logic [2:0] {
    ACEM_NXT_ANY = 3'h0,
    ACEM_NXT_SPECIFIC = 3'h1,
    ACEM_NXT_ICMP = 3'h2,
    ACEM_NXT_UDP = 3'h3,
    ACEM_NXT_TCP = 3'h4
  } acem_nxt_sel_t;
  typedef enum logic [1:0] {
    ACEM_HOP_ANY = 2'h0,
    ACEM_HOP_ZERO = 2'h1,
    ACEM_HOP_NONZERO = 2'h2
  } acem_hop_sel_t;
endpackage

// ==== acem_field_cmp.sv ====
`timescale 1ns/1ps
// ***************************************************************
// masked field comparator with a don't-care bypass
// ***************************************************************
module acem_field_cmp #(
  parameter int W = 8 // field width
) (
  input wire logic enable, // criterion selected as specific
  input wire logic [W-1:0] frame_val, // field from the frame
  input wire logic [W-1:0] cfg_val, // configured value
  input wire logic [W-1:0] cfg_mask, // 1 = bit must match
  output logic match // criterion satisfied
);
  // pattern is value and mask, compared against the masked frame field
  always_comb begin
    match = !enable || ((frame_val & cfg_mask) == (cfg_val & cfg_mask));
  end
endmodule

// ==== acem_matcher.sv ====
`timescale 1ns/1ps
// How it works
// [RQ1] next-header any accepts every value
// [RQ2] icmp, udp, tcp selections restrict protocol
// [RQ3] specific next-header needs exact 8-bit equality
// [RQ4] source address any or specific with mask
// [RQ5] only low 32 source bits compared
// [RQ6] mask zero bit means don't-care bit
// [RQ7] pattern is address and mask
// [RQ8] hop limit zero, non-zero or any
// [RQ9] message type any or specific
// [RQ10] specific type needs exact 8-bit equality
// [RQ11] message code any or specific
// [RQ12] specific code needs exact 8-bit equality
// [RQ13] hit is and of all criteria
// [RQ14] type and code only match icmp frames; code checks them only under the icmp next-header selection
module acem_matcher
  import acem_pkg::*;
(
  input wire logic sys_clk, // 100 MHz clock
  input wire logic reset_n, // asynchronous reset, active low
  input wire logic [3:0] reg_addr, // register word address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, cycle after strobe
  input wire logic frame_valid, // parsed header present
  input wire logic [7:0] frame_next_hdr, // next-header field
  input wire logic [127:0] frame_src_addr, // source address
  input wire logic [7:0] frame_hop_limit, // hop limit field
  input wire logic [7:0] frame_msg_type, // control message type
  input wire logic [7:0] frame_msg_code, // control message code
  output logic hit_valid, // one-cycle result strobe
  output logic hit // entry matched
);
  // ***************************************************************
  // configuration, hit counter, read data and result registers
  // ***************************************************************
  logic [31:0] ctrl_reg; // criterion selections
  logic [31:0] ctrl_next;
  logic [7:0] nxt_val_reg; // next-header value
  logic [7:0] nxt_val_next;
  logic [31:0] source_address_value_reg; // source address value
  logic [31:0] source_address_value_next;
  logic [31:0] source_address_mask_reg; // source address mask
  logic [31:0] source_address_mask_next;
  logic [7:0] control_msg_type_value_reg; // message type value
  logic [7:0] control_msg_type_value_next;
  logic [7:0] control_msg_code_value_reg; // message code value
  logic [7:0] control_msg_code_value_next;
  logic [31:0] hitcnt_reg; // number of hits
  logic [31:0] hitcnt_next;
  logic [31:0] rdata_reg; // registered read data
  logic [31:0] rdata_next;
  logic hit_valid_reg; // result strobe
  logic hit_valid_next;
  logic hit_reg; // result
  logic hit_next;

  // decoded selections
  acem_nxt_sel_t nxt_sel; // next-header criterion
  acem_hop_sel_t hop_sel; // hop-limit criterion
  logic source_address_criterion; // 1 = specific
  logic control_msg_type_criterion; // 1 = specific
  logic control_msg_code_criterion; // 1 = specific
  logic entry_en; // entry enabled

  // per-field results
  logic nxt_ok; // next-header result
  logic src_ok; // source address result
  logic hop_ok; // hop-limit result
  logic type_ok; // message type result
  logic code_ok; // message code result
  logic is_icmp; // frame carries icmpv6
  logic all_ok; // combined result

  // ***************************************************************
  // field decode
  // ***************************************************************
  always_comb begin
    nxt_sel = acem_nxt_sel_t'(ctrl_reg[ACEM_CTRL_NXT_LSB +: 3]);
    hop_sel = acem_hop_sel_t'(ctrl_reg[ACEM_CTRL_HOP_LSB +: 2]);
    source_address_criterion = ctrl_reg[ACEM_CTRL_SRC_BIT];
    control_msg_type_criterion = ctrl_reg[ACEM_CTRL_TYPE_BIT];
    control_msg_code_criterion = ctrl_reg[ACEM_CTRL_CODE_BIT];
    entry_en = ctrl_reg[ACEM_CTRL_EN_BIT];
  end

  // ***************************************************************
  // criterion evaluation
  // ***************************************************************
  assign is_icmp = (frame_next_hdr == ACEM_PROTO_ICMP6);

  // next-header criterion
  always_comb begin
    case (nxt_sel)
      ACEM_NXT_ANY: nxt_ok = 1'b1; // RQ1
      ACEM_NXT_SPECIFIC: nxt_ok = (frame_next_hdr == nxt_val_reg); // RQ3
      ACEM_NXT_ICMP: nxt_ok = is_icmp; // RQ2
      ACEM_NXT_UDP: nxt_ok = (frame_next_hdr == ACEM_PROTO_UDP); // RQ2
      ACEM_NXT_TCP: nxt_ok = (frame_next_hdr == ACEM_PROTO_TCP); // RQ2
      default: nxt_ok = 1'b0; // unused encodings never hit
    endcase
  end

  // source address over the low 32 bits under mask
  acem_field_cmp #(
    .W(32)
  ) u_src_cmp (
    .enable(source_address_criterion), // RQ4
    .frame_val(frame_src_addr[31:0]), // RQ5
    .cfg_val(source_address_value_reg), // RQ7
    .cfg_mask(source_address_mask_reg), // RQ6
    .match(src_ok)
  );

  // hop-limit criterion
  always_comb begin
    case (hop_sel)
      ACEM_HOP_ANY: hop_ok = 1'b1; // RQ8
      ACEM_HOP_ZERO: hop_ok = (frame_hop_limit == 8'h00); // RQ8
      ACEM_HOP_NONZERO: hop_ok = (frame_hop_limit != 8'h00); // RQ8
      default: hop_ok = 1'b1; // reserved setting treated as any
    endcase
  end

  // message type and code only apply when icmp is selected
  always_comb begin
    type_ok = 1'b1;
    code_ok = 1'b1;
    if (nxt_sel == ACEM_NXT_ICMP) begin
      // RQ14
      if (control_msg_type_criterion) begin
        type_ok = is_icmp && (frame_msg_type == control_msg_type_value_reg); // RQ9 RQ10
      end
      if (control_msg_code_criterion) begin
        code_ok = is_icmp && (frame_msg_code == control_msg_code_value_reg); // RQ11 RQ12
      end
    end
  end

  assign all_ok = entry_en && nxt_ok && src_ok && hop_ok && type_ok && code_ok; // RQ13

  // ***************************************************************
  // result and register next state
  // ***************************************************************
  always_comb begin
    ctrl_next = ctrl_reg;
    nxt_val_next = nxt_val_reg;
    source_address_value_next = source_address_value_reg;
    source_address_mask_next = source_address_mask_reg;
    control_msg_type_value_next = control_msg_type_value_reg;
    control_msg_code_value_next = control_msg_code_value_reg;
    hitcnt_next = hitcnt_reg;
    rdata_next = 32'h0000_0000;
    hit_valid_next = frame_valid;
    hit_next = frame_valid && all_ok;
    // hit counter advances on each matched frame, except in a cycle that writes the hit counter
    if (frame_valid && all_ok) begin
      hitcnt_next = hitcnt_reg + 32'h0000_0001;
    end
    // register writes
    if (reg_wr) begin
      if (reg_addr == ACEM_ADDR_CTRL) begin
        ctrl_next = reg_wdata;
      end else if (reg_addr == ACEM_ADDR_NXT_VAL) begin
        nxt_val_next = reg_wdata[7:0];
      end else if (reg_addr == ACEM_ADDR_SRC_VAL) begin
        source_address_value_next = reg_wdata;
      end else if (reg_addr == ACEM_ADDR_SRC_MASK) begin
        source_address_mask_next = reg_wdata;
      end else if (reg_addr == ACEM_ADDR_MSG_VAL) begin
        control_msg_type_value_next = reg_wdata[7:0];
        control_msg_code_value_next = reg_wdata[ACEM_MSG_CODE_LSB +: 8];
      end else if (reg_addr == ACEM_ADDR_HITCNT) begin
        hitcnt_next = ACEM_WORD_RST; // any write clears the counter
      end
    end
    // register reads, unmapped addresses return zero
    if (reg_rd) begin
      if (reg_addr == ACEM_ADDR_CTRL) begin
        rdata_next = ctrl_reg;
      end else if (reg_addr == ACEM_ADDR_NXT_VAL) begin
        rdata_next = {24'h000000, nxt_val_reg};
      end else if (reg_addr == ACEM_ADDR_SRC_VAL) begin
        rdata_next = source_address_value_reg;
      end else if (reg_addr == ACEM_ADDR_SRC_MASK) begin
        rdata_next = source_address_mask_reg;
      end else if (reg_addr == ACEM_ADDR_MSG_VAL) begin
        rdata_next = {16'h0000, control_msg_code_value_reg, control_msg_type_value_reg};
      end else if (reg_addr == ACEM_ADDR_STATUS) begin
        rdata_next = {30'h0000_0000, hit_reg, hit_valid_reg};
      end else if (reg_addr == ACEM_ADDR_HITCNT) begin
        rdata_next = hitcnt_reg;
      end
    end
  end

  // state registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= ACEM_CTRL_RST;
      nxt_val_reg <= ACEM_BYTE_RST;
      source_address_value_reg <= ACEM_WORD_RST;
      source_address_mask_reg <= ACEM_WORD_RST;
      control_msg_type_value_reg <= ACEM_BYTE_RST;
      control_msg_code_value_reg <= ACEM_BYTE_RST;
      hitcnt_reg <= ACEM_WORD_RST;
      rdata_reg <= ACEM_WORD_RST;
      hit_valid_reg <= 1'b0;
      hit_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      nxt_val_reg <= nxt_val_next;
      source_address_value_reg <= source_address_value_next;
      source_address_mask_reg <= source_address_mask_next;
      control_msg_type_value_reg <= control_msg_type_value_next;
      control_msg_code_value_reg <= control_msg_code_value_next;
      hitcnt_reg <= hitcnt_next;
      rdata_reg <= rdata_next;
      hit_valid_reg <= hit_valid_next;
      hit_reg <= hit_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign hit_valid = hit_valid_reg;
  assign hit = hit_reg;

  // ***************************************************************
  // checks
  // ***************************************************************
  a_hit_needs_valid: assert property ( // RQ13
    @(posedge sys_clk) disable iff (!reset_n) hit |-> hit_valid)
    else $error("hit without result strobe");
  a_nxt_any_open: assert property ( // RQ1
    @(posedge sys_clk) disable iff (!reset_n)
    (frame_valid && nxt_sel == ACEM_NXT_ANY && entry_en && src_ok && hop_ok) |=> hit)
    else $error("any next-header blocked a hit");
  a_nxt_spec_eq: assert property ( // RQ3
    @(posedge sys_clk) disable iff (!reset_n)
    (frame_valid && nxt_sel == ACEM_NXT_SPECIFIC && frame_next_hdr != nxt_val_reg) |=> !hit)
    else $error("specific next-header mismatch hit");
  a_nxt_proto_sel: assert property ( // RQ2
    @(posedge sys_clk) disable iff (!reset_n)
    (frame_valid && nxt_sel == ACEM_NXT_TCP && frame_next_hdr != ACEM_PROTO_TCP) |=> !hit)
    else $error("tcp selection hit non-tcp frame");
  a_src_masked: assert property ( // RQ6
    @(posedge sys_clk) disable iff (!reset_n)
    (frame_valid && source_address_criterion && (((frame_src_addr[31:0]
      ^ source_address_value_reg) & source_address_mask_reg) != 32'h0)) |=> !hit)
    else $error("source mismatch under mask hit");
  a_hop_zero: assert property ( // RQ8
    @(posedge sys_clk) disable iff (!reset_n)
    (frame_valid && hop_sel == ACEM_HOP_ZERO && frame_hop_limit != 8'h00) |=> !hit)
    else $error("hop zero setting accepted non-zero");
  a_type_spec: assert property ( // RQ10
    @(posedge sys_clk) disable iff (!reset_n)
    (frame_valid && nxt_sel == ACEM_NXT_ICMP && control_msg_type_criterion
      && frame_msg_type != control_msg_type_value_reg) |=> !hit)
    else $error("type mismatch hit");
  a_code_spec: assert property ( // RQ12
    @(posedge sys_clk) disable iff (!reset_n)
    (frame_valid && nxt_sel == ACEM_NXT_ICMP && control_msg_code_criterion
      && frame_msg_code != control_msg_code_value_reg) |=> !hit)
    else $error("code mismatch hit");
  a_icmp_only: assert property ( // RQ14
    @(posedge sys_clk) disable iff (!reset_n)
    (frame_valid && nxt_sel == ACEM_NXT_ICMP && !is_icmp) |=> !hit)
    else $error("icmp entry hit non-icmp frame");
  a_count_hit: assert property ( // RQ13
    @(posedge sys_clk) disable iff (!reset_n)
    (hit && !$past(reg_wr)) |-> hitcnt_reg == $past(hitcnt_reg) + 32'h1)
    else $error("hit counter did not advance");
  a_valid_follows: assert property ( // RQ13
    @(posedge sys_clk) disable iff (!reset_n) frame_valid |=> hit_valid)
    else $error("result strobe missing after frame");
  a_no_frame_quiet: assert property ( // RQ13
    @(posedge sys_clk) disable iff (!reset_n) !frame_valid |=> !hit_valid)
    else $error("result strobe without frame");
  a_entry_off: assert property ( // RQ13
    @(posedge sys_clk) disable iff (!reset_n)
    (frame_valid && !entry_en) |=> !hit)
    else $error("disabled entry hit");
  a_nxt_udp_sel: assert property ( // RQ2
    @(posedge sys_clk) disable iff (!reset_n)
    (frame_valid && nxt_sel == ACEM_NXT_UDP && frame_next_hdr != ACEM_PROTO_UDP) |=> !hit)
    else $error("udp selection hit non-udp frame");
  a_hop_nonzero: assert property ( // RQ8
    @(posedge sys_clk) disable iff (!reset_n)
    (frame_valid && hop_sel == ACEM_HOP_NONZERO && frame_hop_limit == 8'h00) |=> !hit)
    else $error("hop non-zero setting accepted zero");
  a_src_any_open: assert property ( // RQ4
    @(posedge sys_clk) disable iff (!reset_n)
    (frame_valid && entry_en && nxt_sel == ACEM_NXT_ANY && !source_address_criterion
      && hop_sel == ACEM_HOP_ANY) |=> hit)
    else $error("all don't-care entry missed a frame");
  a_nxt_spec_hit: assert property ( // RQ3
    @(posedge sys_clk) disable iff (!reset_n)
    (frame_valid && entry_en && nxt_sel == ACEM_NXT_SPECIFIC && frame_next_hdr == nxt_val_reg
      && src_ok && hop_ok) |=> hit)
    else $error("specific next-header equal value missed");
  c_hit: cover property (@(posedge sys_clk) disable iff (!reset_n) hit);
  c_icmp_hit: cover property (@(posedge sys_clk) disable iff (!reset_n)
    frame_valid && nxt_sel == ACEM_NXT_ICMP && all_ok);
  c_src_miss: cover property (@(posedge sys_clk) disable iff (!reset_n)
    frame_valid && !src_ok);
  c_read: cover property (@(posedge sys_clk) disable iff (!reset_n) reg_rd);
endmodule

// ==== acem_ingress_model.sv ====
`timescale 1ns/1ps
// ***************************************************************
// ingress pipeline model: hands parsed header fields to the entry
// ***************************************************************
module acem_ingress_model (
  input wire logic sys_clk, // 100 MHz clock
  input wire logic reset_n, // asynchronous reset, active low
  input wire logic send, // present a frame in the next cycle
  input wire logic [159:0] hdr, // {next hdr, source, hop, type, code}
  output logic frame_valid, // one strobe per frame
  output logic [159:0] fields // packed header fields
);
  // between frames the fields flip every cycle, so stale data never looks valid
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_valid <= 1'b0;
      fields <= '0;
    end else if (send) begin
      frame_valid <= 1'b1;
      fields <= hdr;
    end else begin
      frame_valid <= 1'b0;
      fields <= ~fields;
    end
  end
endmodule

// ==== ipv6_icmp_acl_entry_matcher_test.sv ====
`timescale 1ns/1ps
module ipv6_icmp_acl_entry_matcher_test;
  import acem_pkg::*;
  logic sys_clk = 1'b0; // bench clock
  logic reset_n = 1'b0; // reset, active low
  logic [3:0] reg_addr = 4'h0; // register address
  logic [31:0] reg_wdata = 32'h0; // write data
  logic [31:0] reg_rdata; // read data
  logic reg_wr = 1'b0; // write strobe
  logic reg_rd = 1'b0; // read strobe
  logic send = 1'b0; // frame request to the model
  logic [159:0] hdr = '0; // frame fields to the model
  logic [159:0] fl; // fields seen by the entry
  logic frame_valid, hit_valid, hit; // frame path
  logic [31:0] ctrl = 0, nval = 0, sval = 0, smask = 0, mval = 0, hcnt = 0; // shadow state
  logic exp_valid = 1'b0; // result strobe expected now
  logic exp_hit = 1'b0; // result expected now
  int fail_count = 0, num_checks = 0, cycles = 0;
  always #5 sys_clk = ~sys_clk;
  acem_ingress_model i_acem_ingress_model (.sys_clk(sys_clk), .reset_n(reset_n),
    .send(send), .hdr(hdr), .frame_valid(frame_valid), .fields(fl));
  acem_matcher i_acem_matcher (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .frame_valid(frame_valid), .frame_next_hdr(fl[159:152]), .frame_src_addr(fl[151:24]),
    .frame_hop_limit(fl[23:16]), .frame_msg_type(fl[15:8]), .frame_msg_code(fl[7:0]),
    .hit_valid(hit_valid), .hit(hit));
  // ***************************************************************
  // helpers
  // ***************************************************************
  // compare and count
  task automatic check(string what, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  // verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // one-cycle register write
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // one-cycle register read, data checked in the following cycle
  task automatic rd(logic [3:0] a, logic [31:0] e, string what);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    check(what, e, reg_rdata);
    @(negedge sys_clk);
    check({what, "_idle"}, 32'h0, reg_rdata);
  endtask
  // load every criterion and keep the shadow copy
  task automatic cfg(logic [31:0] c, logic [31:0] n, logic [31:0] s, logic [31:0] m,
                     logic [31:0] v);
    ctrl = c;
    nval = n;
    sval = s;
    smask = m;
    mval = v;
    wr(ACEM_ADDR_NXT_VAL, n);
    wr(ACEM_ADDR_SRC_VAL, s);
    wr(ACEM_ADDR_SRC_MASK, m);
    wr(ACEM_ADDR_MSG_VAL, v);
    wr(ACEM_ADDR_CTRL, c);
  endtask
  // expected result of one frame under the shadow configuration
  function automatic logic calc_hit(logic [159:0] f);
    logic ok;
    case (ctrl[2:0])
      3'h0: ok = 1'b1;
      3'h1: ok = (f[159:152] == nval[7:0]);
      3'h2: ok = (f[159:152] == ACEM_PROTO_ICMP6);
      3'h3: ok = (f[159:152] == ACEM_PROTO_UDP);
      3'h4: ok = (f[159:152] == ACEM_PROTO_TCP);
      default: ok = 1'b0;
    endcase
    if (ctrl[4] && ((f[55:24] & smask) != (sval & smask))) ok = 1'b0;
    if (ctrl[9:8] == 2'h1 && f[23:16] != 8'h00) ok = 1'b0;
    if (ctrl[9:8] == 2'h2 && f[23:16] == 8'h00) ok = 1'b0;
    if (ctrl[2:0] == 3'h2 && ctrl[12] && f[15:8] != mval[7:0]) ok = 1'b0;
    if (ctrl[2:0] == 3'h2 && ctrl[13] && f[7:0] != mval[15:8]) ok = 1'b0;
    return ok & ctrl[31];
  endfunction
  // random frames, mostly back to back, biased towards matching values
  task automatic burst(int n);
    logic [159:0] h;
    repeat (n) begin
      @(posedge sys_clk);
      h = {$urandom, $urandom, $urandom, $urandom, $urandom};
      case ($urandom_range(4))
        0: h[159:152] = ACEM_PROTO_ICMP6;
        1: h[159:152] = nval[7:0];
        2: h[159:152] = ACEM_PROTO_UDP;
        3: h[159:152] = ACEM_PROTO_TCP;
        default: ;
      endcase
      if ($urandom_range(1) == 1) h[55:24] = sval ^ ($urandom & ~smask);
      if ($urandom_range(1) == 1) h[23:16] = 8'h00;
      if ($urandom_range(2) != 0) h[15:0] = {mval[7:0], mval[15:8]};
      send <= ($urandom_range(3) != 0);
      hdr <= h;
    end
    @(posedge sys_clk);
    send <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  // ***************************************************************
  // result monitor and hang guard
  // ***************************************************************
  always @(negedge sys_clk) begin
    if (reset_n) begin
      check("hit_valid", {31'h0, exp_valid}, {31'h0, hit_valid});
      if (exp_valid) check("hit", {31'h0, exp_hit}, {31'h0, hit});
      exp_valid = frame_valid;
      exp_hit = frame_valid && calc_hit(fl);
      if (exp_hit) hcnt = hcnt + 1;
    end
    cycles++;
    if (cycles > 20000) begin
      fail_count++;
      results();
    end
  end
  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    logic [31:0] c;
    void'($urandom(99));
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    // reset values and an unmapped place
    for (int a = 0; a < 7; a++) rd(a[3:0], 32'h0, "reset_value");
    wr(4'h7, 32'hffff_ffff);
    rd(4'h7, 32'h0, "unmapped");
    $display("test reset done");
    // every next-header selection with random other criteria
    for (int s = 0; s < 8; s++) begin
      repeat (4) begin
        c = $urandom & 32'h0000_3310;
        c[2:0] = s[2:0];
        c[31] = ($urandom_range(7) != 0);
        cfg(c, $urandom & 32'hff, $urandom, $urandom | $urandom, $urandom & 32'hffff);
        rd(ACEM_ADDR_CTRL, c, "ctrl");
        burst(30);
        rd(ACEM_ADDR_HITCNT, hcnt, "hit_count");
      end
    end
    $display("test selections done");
    // low-bit don't-care mask: only low words 2 and 3 hit
    wr(ACEM_ADDR_HITCNT, 32'h0);
    hcnt = 0;
    cfg(32'h8000_0010, 32'h0, 32'h3, 32'hffff_fffe, 32'h0);
    for (int k = 1; k < 4; k++) begin
      @(posedge sys_clk);
      send <= 1'b1;
      hdr <= {8'h3a, $urandom, $urandom, $urandom, 32'(k), 24'h0};
    end
    @(posedge sys_clk);
    send <= 1'b0;
    rd(ACEM_ADDR_STATUS, 32'h3, "status");
    rd(ACEM_ADDR_HITCNT, 32'h2, "mask_hits");
    $display("test mask done");
    // every criterion don't-care: every frame hits
    cfg(32'h8000_0000, 32'h0, 32'h0, 32'h0, 32'h0);
    burst(20);
    rd(ACEM_ADDR_HITCNT, hcnt, "all_any_hits");
    $display("test all any done");
    results();
  end
endmodule
